// ---- dv/nco_core_properties.sv ----
/* Checker of the register bus and waveform relations of nco_core.
   Assumes the selected source rises at least once in every 8 clocks. */
`timescale 1ns/100ps
module nco_core_properties
    import nco_pkg::*;
(
    // Clock and reset
    input  wire logic               CLK_I,
    input  wire logic               RST_N_I,
    // APB
    input  wire logic               PSEL_I,
    input  wire logic               PENABLE_I,
    input  wire logic               PWRITE_I,
    input  wire logic [PADDR_W-1:0] PADDR_I,
    input  wire logic               PREADY_O,
    input  wire logic [31:0]        PRDATA_O,
    input  wire logic               PSLVERR_O,
    // Waveform
    input  wire logic               ACC_CARRY_O,
    input  wire logic               NCO_OUT_O,
    input  wire logic               PULSE_MODE_O
);
    logic                           setup_rd;
    logic                           unmapped;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    assign setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
    // Anything past the last word or off alignment has no register
    assign unmapped = (PADDR_I > OFS_INC_HIGH) || (PADDR_I[1:0] != 2'h0);

    a_zero_wait:
    assert property (PREADY_O == (PSEL_I && PENABLE_I))
        else $error("ready does not follow the access phase");
    a_rdata_holds:
    assert property (PSEL_I && PENABLE_I && !PWRITE_I |=> $stable(PRDATA_O))
        else $error("read data moved after the access");
    a_upper_bytes_zero:
    assert property (PSEL_I && PENABLE_I |-> PRDATA_O[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    a_acc_upper_zero:
    assert property (setup_rd && PADDR_I == OFS_ACC_UPPER
                     |=> PRDATA_O[7:4] == 4'h0)
        else $error("upper accumulator bits 7:4 not zero");
    a_cfg_gap_zero:
    assert property (setup_rd && PADDR_I == OFS_CLK_CFG
                     |=> PRDATA_O[4:2] == 3'h0)
        else $error("clock config bits 4:2 not zero");
    a_slverr_map:
    assert property (PSEL_I && !PENABLE_I |=> PSLVERR_O == $past(unmapped))
        else $error("error response does not match the map");
    a_carry_single:
    assert property (ACC_CARRY_O |=> !ACC_CARRY_O)
        else $error("carry wider than one cycle");
    a_toggle_follows:
    assert property (ACC_CARRY_O && !PULSE_MODE_O
                     |-> ##[1:16] $changed(NCO_OUT_O))
        else $error("toggle mode output did not change after carry");
    a_pulse_follows:
    assert property (ACC_CARRY_O && PULSE_MODE_O && !NCO_OUT_O
                     |-> ##[1:16] $rose(NCO_OUT_O))
        else $error("pulse mode output did not rise after carry");
endmodule

bind nco_core nco_core_properties u_nco_core_properties (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
    .ACC_CARRY_O(ACC_CARRY_O), .NCO_OUT_O(NCO_OUT_O),
    .PULSE_MODE_O(PULSE_MODE_O)
);

// ---- dv/nco_osc_sources.sv ----
/* Model of the four oscillator sources feeding the core.
   Source i has a period of 2*(i+1) clocks; hold freezes all levels,
   standing for sources that are stopped. */
`timescale 1ns/100ps
module nco_osc_sources
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Control and sources
    input  wire logic       hold_i,
    output logic [3:0]      src_o
);
    logic [2:0]             cnt [4];

    // each rising level is one tick
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            src_o <= 4'h0;
            for (int i = 0; i < 4; i++)
                cnt[i] <= 3'h0;
        end
        else if (!hold_i)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (cnt[i] == 3'(i))
                begin
                    cnt[i]   <= 3'h0;
                    src_o[i] <= ~src_o[i];
                end
                else
                    cnt[i] <= cnt[i] + 3'h1;
            end
        end
    end
endmodule

// ---- dv/tb_nco_core.sv ----
/* Self-checking bench of nco_core: APB master tasks and source model.
   Assumes the zero-wait slave; every wait is bounded. */
`timescale 1ns/100ps
module tb_nco_core import nco_pkg::*;;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_t;

    logic               clk;
    logic               rst_n;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [PADDR_W-1:0] paddr;
    logic [31:0]        pwdata;
    logic [3:0]         pstrb;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               hold;
    logic [3:0]         src;
    logic               carry;
    logic               wave;
    logic               pmode;
    logic               pin;
    logic               pin_oe_n;
    logic [31:0]        rd;
    int                 mismatches;
    int                 num_checks;
    int                 n;
    row_t               rows [8] = '{
        '{OFS_CLK_CFG, 8'hFF, 8'hE3}, '{OFS_ACC_LOW, 8'hA5, 8'hA5},
        '{OFS_ACC_HIGH, 8'h5A, 8'h5A}, '{OFS_ACC_UPPER, 8'hFF, 8'h0F},
        '{OFS_INC_HIGH, 8'h12, 8'h12}, '{OFS_INC_LOW, 8'h34, 8'h34},
        '{8'h1C, 8'hFF, 8'h00}, '{OFS_CTRL, 8'h0F, 8'h01}};

    nco_core u_nco_core (
        .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .HF_OSC_CLK_I(src[0]),
        .SYS_OSC_CLK_I(src[1]), .LOGIC_CELL_OUT_I(src[2]),
        .EXT_CLK_PIN_I(src[3]), .ACC_CARRY_O(carry), .NCO_OUT_O(wave),
        .PULSE_MODE_O(pmode), .NCO_PIN_O(pin), .NCO_PIN_OE_N_O(pin_oe_n));
    nco_osc_sources u_nco_osc_sources (
        .clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .src_o(src));

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic guard(input int c);
        if (c >= 3000)
        begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 3000);
        guard(k);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rd);
    endtask

    // Cycles from one carry to the next
    task automatic period(output int c);
        c = 0;
        while (carry !== 1'b1 && c < 3000)
        begin
            @(posedge clk);
            c++;
        end
        guard(c);
        c = 0;
        do
        begin
            @(posedge clk);
            c++;
        end
        while (carry !== 1'b1 && c < 3000);
        guard(c);
    endtask

    // Length of one whole high phase of the waveform
    task automatic high_len(output int c);
        c = 0;
        while (wave !== 1'b0 && c < 3000)
        begin
            @(posedge clk);
            c++;
        end
        guard(c);
        c = 0;
        while (wave !== 1'b1 && c < 3000)
        begin
            @(posedge clk);
            c++;
        end
        guard(c);
        c = 0;
        while (wave === 1'b1 && c < 3000)
        begin
            @(posedge clk);
            c++;
        end
        guard(c);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        hold = 1'b1;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 0; a <= 24; a += 4)
        begin
            apb(1'b0, 8'(a), 32'h0, rd);
            check(rd, {31'h0, 8'(a) == OFS_INC_LOW});
        end
        foreach (rows[i])
        begin
            wr(rows[i].addr, rows[i].wdata);
            apb(1'b0, rows[i].addr, 32'h0, rd);
            check(rd, {24'h0, rows[i].exp});
        end
        // A write with its byte strobe off must leave the byte alone
        pstrb <= 4'h0;
        wr(OFS_ACC_LOW, 8'hFF);
        pstrb <= 4'hF;
        apb(1'b0, OFS_ACC_LOW, 32'h0, rd);
        check(rd, 32'hA5);
        // An unmapped word answers with the error flag
        apb(1'b0, 8'h1C, 32'h0, rd);
        check({31'h0, pslverr}, 32'h1);
        // high byte first; enable is off, so each byte write loads the buffer at once
        wr(OFS_CTRL, 8'h00);
        wr(OFS_INC_HIGH, 8'h80);
        wr(OFS_INC_LOW, 8'h00);
        wr(OFS_CTRL, 8'h80);
        hold <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CLK_CFG, 8'h20 | 8'(s));
            period(n);
            check(n, 64 * (s + 1));
        end
        high_len(n);
        check(n, 256);
        wr(OFS_CTRL, 8'h81);
        check({31'h0, pmode}, 32'h1);
        high_len(n);
        high_len(n);
        check(n, 16);
        // a long overflow period keeps every width legal
        wr(OFS_INC_HIGH, 8'h08);
        wr(OFS_INC_LOW, 8'h00);
        wr(OFS_CLK_CFG, 8'h00);
        period(n);
        period(n);
        check(n, 1024);
        for (int w = 0; w < 8; w++)
        begin
            wr(OFS_CLK_CFG, {3'(w), 5'h0});
            high_len(n);
            high_len(n);
            check(n, 2 << w);
        end
        // Pin driven with the waveform, one cycle behind it
        wr(OFS_CTRL, 8'hC1);
        high_len(n);
        check({30'h0, pin, pin_oe_n}, 32'h2);
        @(posedge clk);
        check({30'h0, pin, pin_oe_n}, 32'h0);
        // Reset in mid-run brings back the pin, pulse mode, low increment, clock config and upper accumulator
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check({30'h0, pin, pin_oe_n}, 32'h1);
        check({31'h0, pmode}, 32'h0);
        apb(1'b0, OFS_INC_LOW, 32'h0, rd);
        check(rd, 32'h1);
        apb(1'b0, OFS_CLK_CFG, 32'h0, rd);
        check(rd, 32'h0);
        apb(1'b0, OFS_ACC_UPPER, 32'h0, rd);
        check(rd, 32'h0);
        summarize();
    end
endmodule

// ---- rtl/nco_clock_select.sv ----
/*
 * Oscillator source selection and rising-edge detection.
 * Assumes all source levels are already synchronous to CLK_I and run
 * below half its rate, so each rising source edge shows as one tick.
 */
`timescale 1ns/100ps
module nco_clock_select
    import nco_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Sources and selection
    input  wire logic [3:0] src_i,
    input  clk_src_t        sel_i,
    // One-cycle tick per rising edge of the selected source
    output logic            tick_o
);

    logic sel_level;
    logic prev_level;

    // Source mux
    always_comb
    begin
        case (sel_i)
            SRC_HF_OSC:     sel_level = src_i[0];
            SRC_SYS_OSC:    sel_level = src_i[1];
            SRC_LOGIC_CELL: sel_level = src_i[2];
            SRC_EXT_PIN:    sel_level = src_i[3];
            default:        sel_level = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prev_level <= 1'b0;
        else
            prev_level <= sel_level;
    end

    // A source switch may yield one stray tick; software switches disabled
    assign tick_o = sel_level & ~prev_level;

endmodule

// ---- rtl/nco_core.sv ----
/*
 * Numerically controlled oscillator register slice: APB register file,
 * 20-bit phase accumulator, double-buffered 16-bit increment, source
 * select and output stage.
 * Assumes a zero-wait APB master and oscillator sources that are
 * synchronous to CLK_I and slower than half its rate.
 */
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module nco_core
    import nco_pkg::*;
(
    // Clock and reset
    input  wire logic               CLK_I,
    input  wire logic               RST_N_I,
    // APB slave
    input  wire logic               PSEL_I,
    input  wire logic               PENABLE_I,
    input  wire logic               PWRITE_I,
    input  wire logic [PADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]        PWDATA_I,
    input  wire logic [3:0]         PSTRB_I,
    output logic                    PREADY_O,
    output logic [31:0]             PRDATA_O,
    output logic                    PSLVERR_O,
    // Oscillator sources
    input  wire logic               HF_OSC_CLK_I,
    input  wire logic               SYS_OSC_CLK_I,
    input  wire logic               LOGIC_CELL_OUT_I,
    input  wire logic               EXT_CLK_PIN_I,
    // Waveform and events
    output logic                    ACC_CARRY_O,
    output logic                    NCO_OUT_O,
    output logic                    PULSE_MODE_O,
    output logic                    NCO_PIN_O,
    output logic                    NCO_PIN_OE_N_O
);

    ctrl_t              ctrl;
    clk_cfg_t           clk_cfg;
    logic [ACC_W-1:0]   acc;
    logic [INC_W-1:0]   inc_sw;
    logic [INC_W-1:0]   inc_buf;
    logic [1:0]         inc_pend;
    logic               inc_imm;
    logic               carry;
    logic               tick;
    logic               nco_out;
    logic [ACC_W:0]     next_sum;
    logic               setup;
    logic               access;
    logic               wr_byte;
    logic [7:0]         wdata;
    logic [7:0]         next_rdata;
    logic               next_err;
    logic               buf_load;

    function automatic logic hit(input logic [PADDR_W-1:0] addr,
                                 input logic [7:0]         ofs);
        hit = (addr == ofs);
    endfunction

    // Unmapped words answer with an error and read as zero
    function automatic logic mapped(input logic [PADDR_W-1:0] addr);
        mapped = hit(addr, OFS_CTRL)      || hit(addr, OFS_CLK_CFG)   ||
                 hit(addr, OFS_ACC_LOW)   || hit(addr, OFS_ACC_HIGH)  ||
                 hit(addr, OFS_ACC_UPPER) || hit(addr, OFS_INC_LOW)   ||
                 hit(addr, OFS_INC_HIGH);
    endfunction

    // Bus phases; zero-wait slave, answers in the first access cycle
    assign setup    = PSEL_I & ~PENABLE_I;
    assign access   = PSEL_I & PENABLE_I;
    assign PREADY_O = access;
    // Registers sit in byte lane 0, so only its strobe gates a write
    assign wr_byte  = access & PWRITE_I & PSTRB_I[0] & mapped(PADDR_I);
    assign wdata    = PWDATA_I[7:0];

    // Read data and error captured at setup so the data come from flops
    always_comb
    begin
        next_rdata = 8'h00;
        next_err   = ~mapped(PADDR_I);
        case (1'b1)
            hit(PADDR_I, OFS_CTRL):
            begin
                next_rdata[CTRL_EN_BIT]  = ctrl.en;
                next_rdata[CTRL_OE_BIT]  = ctrl.oe;
                next_rdata[CTRL_OUT_BIT] = nco_out;
                next_rdata[CTRL_POL_BIT] = ctrl.pol;
                next_rdata[CTRL_PFM_BIT] = ctrl.pfm;
            end
            hit(PADDR_I, OFS_CLK_CFG):
            begin
                next_rdata[CFG_PWS_LSB +: 3] = clk_cfg.pws;
                next_rdata[CFG_CKS_LSB +: 2] = clk_cfg.cks;
            end
            hit(PADDR_I, OFS_ACC_LOW):   next_rdata = acc[7:0];
            hit(PADDR_I, OFS_ACC_HIGH):  next_rdata = acc[15:8];
            hit(PADDR_I, OFS_ACC_UPPER): next_rdata = {4'h0, acc[19:16]};
            hit(PADDR_I, OFS_INC_LOW):   next_rdata = inc_sw[7:0];
            hit(PADDR_I, OFS_INC_HIGH):  next_rdata = inc_sw[15:8];
            default:                     next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            PRDATA_O  <= 32'h00000000;
            PSLVERR_O <= 1'b0;
        end
        else if (setup)
        begin
            PRDATA_O  <= {24'h000000, next_rdata};
            PSLVERR_O <= next_err;
        end
    end

    // Control register
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ctrl <= CTRL_RESET;
        else if (wr_byte && hit(PADDR_I, OFS_CTRL))
        begin
            ctrl.en  <= wdata[CTRL_EN_BIT];
            ctrl.oe  <= wdata[CTRL_OE_BIT];
            ctrl.pol <= wdata[CTRL_POL_BIT];
            ctrl.pfm <= wdata[CTRL_PFM_BIT];
        end
    end

    // Clock and pulse width configuration
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            clk_cfg <= CLK_CFG_RESET;
        else if (wr_byte && hit(PADDR_I, OFS_CLK_CFG))
        begin
            clk_cfg.pws <= wdata[CFG_PWS_LSB +: 3];
            clk_cfg.cks <= clk_src_t'(wdata[CFG_CKS_LSB +: 2]);
        end
    end

    // Software view of the increment
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            inc_sw <= INC_RESET;
        else if (wr_byte)
        begin
            if (hit(PADDR_I, OFS_INC_LOW))
                inc_sw[7:0] <= wdata;
            if (hit(PADDR_I, OFS_INC_HIGH))
                inc_sw[15:8] <= wdata;
        end
    end

    // Load scheduling; relies on the high byte being written first
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            inc_imm <= 1'b0;
        else
            inc_imm <= wr_byte & ~ctrl.en &
                       (hit(PADDR_I, OFS_INC_LOW) |
                        hit(PADDR_I, OFS_INC_HIGH));
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            inc_pend <= 2'h0;
        else if (wr_byte && ctrl.en && hit(PADDR_I, OFS_INC_LOW))
            inc_pend <= INC_LOAD_TICKS;
        else if (buf_load)
            inc_pend <= 2'h0;
        else if (tick && inc_pend != 2'h0)
            inc_pend <= inc_pend - 2'h1;
    end

    // Disabling while a load waits loads at once rather than stalling
    assign buf_load = inc_imm |
                      (inc_pend != 2'h0 && !ctrl.en) |
                      (tick && inc_pend == 2'h1);

    // Buffer is what the adder sees; software never reads it
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            inc_buf <= INC_RESET;
        else if (buf_load)
            inc_buf <= inc_sw;
    end

    nco_clock_select u_clock_select (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .src_i   ({EXT_CLK_PIN_I, LOGIC_CELL_OUT_I,
                   SYS_OSC_CLK_I, HF_OSC_CLK_I}),
        .sel_i   (clk_cfg.cks),
        .tick_o  (tick)
    );

    // One bit wider so the carry out of bit 19 survives
    assign next_sum = {1'b0, acc} + {5'h00, inc_buf};

    // Accumulator; a software byte write wins over that tick's add
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            acc <= ACC_RESET;
        else if (wr_byte && hit(PADDR_I, OFS_ACC_LOW))
            acc[7:0] <= wdata;
        else if (wr_byte && hit(PADDR_I, OFS_ACC_HIGH))
            acc[15:8] <= wdata;
        else if (wr_byte && hit(PADDR_I, OFS_ACC_UPPER))
            acc[19:16] <= wdata[3:0];
        else if (tick && ctrl.en)
            acc <= next_sum[ACC_W-1:0];
    end

    // Registered so the carry leaves as a clean one-cycle pulse
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            carry <= 1'b0;
        else
            carry <= tick & ctrl.en & next_sum[ACC_W] &
                     ~(wr_byte & (hit(PADDR_I, OFS_ACC_LOW) |
                                  hit(PADDR_I, OFS_ACC_HIGH) |
                                  hit(PADDR_I, OFS_ACC_UPPER)));
    end

    nco_output_stage u_output_stage (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .tick_i  (tick),
        .carry_i (carry),
        .en_i    (ctrl.en),
        .pfm_i   (ctrl.pfm),
        .pol_i   (ctrl.pol),
        .pws_i   (clk_cfg.pws),
        .out_o   (nco_out)
    );

    // Pin is driven low while the pin enable is off
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            NCO_PIN_O <= 1'b0;
        else
            NCO_PIN_O <= nco_out & ctrl.oe & ctrl.en;
    end

    // Enable is low while driving, so the pad floats through reset
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            NCO_PIN_OE_N_O <= 1'b1;
        else
            NCO_PIN_OE_N_O <= ~(ctrl.oe & ctrl.en);
    end

    assign ACC_CARRY_O  = carry;
    assign NCO_OUT_O    = nco_out;
    assign PULSE_MODE_O = ctrl.pfm;

endmodule

// ---- rtl/nco_output_stage.sv ----
/*
 * Output stage: toggles on overflow in fixed duty mode, or stretches a
 * pulse of 2**width ticks in pulse frequency mode, then applies polarity.
 * Assumes tick and carry from the accumulator, same clock.
 */
`timescale 1ns/100ps
module nco_output_stage
    import nco_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Timing
    input  wire logic       tick_i,
    input  wire logic       carry_i,
    // Configuration
    input  wire logic       en_i,
    input  wire logic       pfm_i,
    input  wire logic       pol_i,
    input  wire logic [2:0] pws_i,
    // Output
    output logic            out_o
);

    logic                carry_seen;
    logic                raw_out;
    logic [PW_CNT_W-1:0] pw_cnt;

    // Set wins over the clear taken by the next tick
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            carry_seen <= 1'b0;
        else if (carry_i)
            carry_seen <= 1'b1;
        else if (tick_i)
            carry_seen <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            raw_out <= 1'b0;
            pw_cnt  <= PW_CNT_RESET;
        end
        else if (!en_i)
        begin
            raw_out <= 1'b0;
            pw_cnt  <= PW_CNT_RESET;
        end
        else if (tick_i)
        begin
            if (!pfm_i)
            begin
                if (carry_seen)
                    raw_out <= ~raw_out;
                pw_cnt <= PW_CNT_RESET;
            end
            else if (carry_seen)
            begin
                raw_out <= 1'b1;
                pw_cnt  <= (8'h01 << pws_i) - 8'h01;
            end
            else if (pw_cnt != PW_CNT_RESET)
                pw_cnt <= pw_cnt - 8'h01;
            else
                raw_out <= 1'b0;
        end
    end

    assign out_o = raw_out ^ pol_i;

endmodule

// ---- rtl/nco_pkg.sv ----
/*
 * Shared constants and types of the numerically controlled oscillator:
 * register offsets, field positions, reset values and carriers.
 * Assumes a 32-bit APB register bus with byte-wide registers in bit 7:0.
 */
package nco_pkg;

    localparam int          ACC_W          = 20;
    localparam int          INC_W          = 16;
    localparam int          PADDR_W        = 8;
    localparam int          PW_CNT_W       = 8;

    // Register byte addresses, one aligned word each
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_CLK_CFG    = 8'h04;
    localparam logic [7:0]  OFS_ACC_LOW    = 8'h08;
    localparam logic [7:0]  OFS_ACC_HIGH   = 8'h0C;
    localparam logic [7:0]  OFS_ACC_UPPER  = 8'h10;
    localparam logic [7:0]  OFS_INC_LOW    = 8'h14;
    localparam logic [7:0]  OFS_INC_HIGH   = 8'h18;

    // Field positions of oscillator_control
    localparam int          CTRL_EN_BIT    = 7;
    localparam int          CTRL_OE_BIT    = 6;
    localparam int          CTRL_OUT_BIT   = 5;
    localparam int          CTRL_POL_BIT   = 4;
    localparam int          CTRL_PFM_BIT   = 0;

    // Field positions of clock_pulse_config
    localparam int          CFG_PWS_LSB    = 5;
    localparam int          CFG_CKS_LSB    = 0;

    // Reset values and the increment load delay in ticks
    localparam logic [19:0] ACC_RESET      = 20'h00000;
    localparam logic [15:0] INC_RESET      = 16'h0001;
    localparam logic [1:0]  INC_LOAD_TICKS = 2'h2;
    localparam logic [7:0]  PW_CNT_RESET   = 8'h00;

    // Nominal rate of the internal high-frequency source, in MHz
    localparam int          HF_OSC_MHZ     = 16;

    typedef enum logic [1:0] {
        SRC_HF_OSC,
        SRC_SYS_OSC,
        SRC_LOGIC_CELL,
        SRC_EXT_PIN
    } clk_src_t;

    typedef struct packed {
        logic       en;
        logic       oe;
        logic       pol;
        logic       pfm;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] pws;
        clk_src_t   cks;
    } clk_cfg_t;

    localparam ctrl_t       CTRL_RESET     = '{en: 1'b0, oe: 1'b0,
                                               pol: 1'b0, pfm: 1'b0};
    localparam clk_cfg_t    CLK_CFG_RESET  = '{pws: 3'h0,
                                               cks: SRC_HF_OSC};

endpackage
